// [two_wire_regs.svh]
// Register offsets, field positions, reset values, status codes and timing counts
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH
`define OFS_BIT_RATE 8'hB8
`define OFS_STATUS 8'hB9
`define OFS_OWN_ADDR 8'hBA
`define OFS_DATA 8'hBB
`define OFS_CONTROL 8'hBC
`define RST_BIT_RATE 8'h00
`define RST_OWN_ADDR 8'hFE
`define RST_DATA 8'hFF
`define RST_PRESCALE 2'h0
`define CTL_FLAG 7
`define CTL_ACK_EN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_WCOL 3
`define CTL_ENABLE 2
`define CTL_IRQ_EN 0
`define ADDR_GC_EN 0
`define CODE_MSB 7
`define CODE_LSB 3
`define GC_ADDR 7'h00
`define SC_IDLE 8'hF8
`define SC_BUS_ERR 8'h00
`define SC_START 8'h08
`define SC_RSTART 8'h10
`define SC_MTX_SLA_ACK 8'h18
`define SC_MTX_SLA_NACK 8'h20
`define SC_MTX_DATA_ACK 8'h28
`define SC_MTX_DATA_NACK 8'h30
`define SC_ARB_LOST 8'h38
`define SC_MRX_SLA_ACK 8'h40
`define SC_MRX_SLA_NACK 8'h48
`define SC_MRX_DATA_ACK 8'h50
`define SC_MRX_DATA_NACK 8'h58
`define SC_SRX_SLA 8'h60
`define SC_SRX_ARB_SLA 8'h68
`define SC_SRX_GC 8'h70
`define SC_SRX_ARB_GC 8'h78
`define SC_SRX_DATA_ACK 8'h80
`define SC_SRX_DATA_NACK 8'h88
`define SC_SRX_GC_ACK 8'h90
`define SC_SRX_GC_NACK 8'h98
`define SC_SRX_STOP 8'hA0
`define SC_STX_SLA 8'hA8
`define SC_STX_ARB_SLA 8'hB0
`define SC_STX_DATA_ACK 8'hB8
`define SC_STX_DATA_NACK 8'hC0
`define HALF_BASE 16'h0008
`define BIT_ERR_MIN 4'h2
`define ACK_SLOT 4'h8
`define BYTE_END 4'h9
`endif

// [two_wire_pkg.sv]
// Types shared by the two-wire unit
package two_wire_pkg;
	typedef enum logic [2:0] {S_IDLE, S_START, S_BYTE, S_HOLD, S_STOP, S_ERROR} state_t;
endpackage : two_wire_pkg

// [bus_link_if.sv]
// Sampled bus levels and bus events passed from the line monitor to the core
`timescale 1ns/1ps
interface bus_link_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic busy;
	modport mon (output scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
	modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
endinterface : bus_link_if

// [bus_monitor.sv]
// Line synchroniser and START/STOP/edge detector for the two-wire bus
`timescale 1ns/1ps
module bus_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Bus lines
	input wire logic scl_pin,
	input wire logic sda_pin,
	// Events
	bus_link_if.mon link
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic busy_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_pin};
			sda_sync_reg <= {sda_sync_reg[0], sda_pin};
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign link.scl = scl_sync_reg[1];
	assign link.sda = sda_sync_reg[1];
	assign link.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
	assign link.scl_fall = !scl_sync_reg[1] && scl_prev_reg;
	// Data moving while the clock stays high marks START or STOP
	assign link.start_det = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
	assign link.stop_det = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
	assign link.busy = busy_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
		end else if (link.start_det) begin
			busy_reg <= 1'b1;
		end else if (link.stop_det) begin
			busy_reg <= 1'b0;
		end
	end
endmodule : bus_monitor

// [i2c_unit.sv]
// Byte-oriented two-wire unit: master/slave engine, bus error and arbitration handling
// How it works
// R1: With the done flag clear the status field reads the idle code.
// R2: Idle code also shows between states and when no transfer involves us.
// R3: Software leaves data and control alone while idle code is shown.
// R4: START or STOP inside a byte or acknowledge gives the bus-error code; the unit checks only from the second bit of a byte on.
// R5: A bus error sets the done flag.
// R6: Software recovers with stop request set and the done flag written one.
// R7: Recovery enters unaddressed slave and clears the stop request only.
// R8: Recovery releases both lines and sends no STOP.
// R9: Repeated START keeps bus ownership without a STOP.
// R10: Software does address-write then read as one repeated-START transfer.
// R11: Masters sending identical bits see no contention.
// R12: Released data line sampled low while clocking means arbitration lost.
// R13: Arbitration lets the winner finish with no data lost.
// R14: After losing, unaddressed unit idles or restarts as the start request says.
// R15: Losing during the address turns the unit into a comparing slave.
// R16: Addressed after losing, enter slave receive or transmit by direction bit.
// R17: Lost and unaddressed gives a releasing code; addressed gives distinct codes.
// R18: Status code sits in bits 7:3, prescaler in bits 1:0.
// R19: While the done flag is set the clock line is held low, except after a bus error, unaddressed lost arbitration or a slave STOP, which release it.
// R20: Bus-error detection runs whenever enabled, as master or slave; an unaddressed slave stops checking after the address byte.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module i2c_unit (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Two-wire pins
	input wire logic scl_line,
	output logic scl_value,
	output logic scl_drive_en,
	input wire logic sda_line,
	output logic sda_value,
	output logic sda_drive_en
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	bus_link_if link();

	bus_monitor u_mon (
		.mclk(mclk),
		.nrst(nrst),
		.scl_pin(scl_line),
		.sda_pin(sda_line),
		.link(link)
	);

	logic [7:0] rate_reg;
	logic [7:0] own_addr_reg;
	logic [7:0] data_reg;
	logic [1:0] prescale_reg;
	logic flag_reg;
	logic ack_en_reg;
	logic start_reg;
	logic stop_reg;
	logic wcol_reg;
	logic enable_reg;
	logic irq_en_reg;
	logic go_reg;
	logic [7:0] code_reg;
	logic set_pulse_reg;
	logic stop_clr_reg;
	logic latch_reg;
	two_wire_pkg::state_t state_reg;
	logic [1:0] phase_reg;
	logic [15:0] cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic master_reg;
	logic tx_reg;
	logic addr_phase_reg;
	logic addressed_reg;
	logic gc_reg;
	logic lost_reg;
	logic ack_seen_reg;
	logic leave_reg;
	logic scl_low_reg;
	logic sda_low_reg;
	logic ctl_wr;
	logic data_wr;
	logic timed;
	logic need_high;
	logic adv;
	logic own_hit;
	logic gc_hit;
	logic [15:0] half_len;

	assign ctl_wr = reg_write && hit(reg_addr, `OFS_CONTROL);
	assign data_wr = reg_write && hit(reg_addr, `OFS_DATA);
	assign half_len = `HALF_BASE + (16'(rate_reg) << {prescale_reg, 1'b0});
	assign own_hit = ack_en_reg && (shift_reg[7:1] == own_addr_reg[7:1]);
	assign gc_hit = ack_en_reg && own_addr_reg[`ADDR_GC_EN] && (shift_reg[7:1] == `GC_ADDR);

	// R8 open-drain drive
	assign scl_value = 1'b0;
	assign sda_value = 1'b0;
	assign scl_drive_en = scl_low_reg;
	assign sda_drive_en = sda_low_reg;

	// Software-written configuration
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rate_reg <= `RST_BIT_RATE;
			own_addr_reg <= `RST_OWN_ADDR;
			prescale_reg <= `RST_PRESCALE;
		end else if (reg_write) begin
			if (hit(reg_addr, `OFS_BIT_RATE))
				rate_reg <= reg_wdata;
			if (hit(reg_addr, `OFS_OWN_ADDR))
				own_addr_reg <= reg_wdata;
			if (hit(reg_addr, `OFS_STATUS))
				prescale_reg <= reg_wdata[1:0];
		end
	end

	// Control bits
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ack_en_reg <= 1'b0;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			enable_reg <= 1'b0;
			irq_en_reg <= 1'b0;
		end else if (ctl_wr) begin
			ack_en_reg <= reg_wdata[`CTL_ACK_EN];
			start_reg <= reg_wdata[`CTL_START];
			stop_reg <= reg_wdata[`CTL_STOP];
			enable_reg <= reg_wdata[`CTL_ENABLE];
			irq_en_reg <= reg_wdata[`CTL_IRQ_EN];
		end else if (stop_clr_reg) begin
			// R7 hardware clears stop
			stop_reg <= 1'b0;
		end
	end

	// Done flag: a hardware set wins over a software clear
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			flag_reg <= 1'b0;
			go_reg <= 1'b0;
		end else begin
			// R5 flag set on event
			if (set_pulse_reg)
				flag_reg <= 1'b1;
			else if (ctl_wr && reg_wdata[`CTL_FLAG])
				flag_reg <= 1'b0;
			go_reg <= ctl_wr && reg_wdata[`CTL_FLAG] && flag_reg && !set_pulse_reg;
		end
	end

	// Data byte and write collision
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			data_reg <= `RST_DATA;
			wcol_reg <= 1'b0;
		end else if (latch_reg) begin
			// R13 received byte kept across arbitration loss
			data_reg <= shift_reg;
		end else if (data_wr) begin
			if (flag_reg) begin
				data_reg <= reg_wdata;
				wcol_reg <= 1'b0;
			end else begin
				wcol_reg <= 1'b1;
			end
		end
	end

	// Read data stands for one cycle only
	always_ff @(posedge mclk) begin
		if (!nrst || !reg_read) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`OFS_BIT_RATE: reg_rdata <= rate_reg;
				// R1 R2 R18 idle code unless flag set
				`OFS_STATUS: reg_rdata <= {(flag_reg ? code_reg[`CODE_MSB:`CODE_LSB] :
					5'(`SC_IDLE >> `CODE_LSB)), 1'b0, prescale_reg};
				`OFS_OWN_ADDR: reg_rdata <= own_addr_reg;
				`OFS_DATA: reg_rdata <= data_reg;
				`OFS_CONTROL: reg_rdata <= {flag_reg, ack_en_reg, start_reg, stop_reg,
					wcol_reg, enable_reg, 1'b0, irq_en_reg};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Half-period timer for generated clock, START and STOP
	assign timed = (state_reg == two_wire_pkg::S_START) || (state_reg == two_wire_pkg::S_STOP) ||
		((state_reg == two_wire_pkg::S_BYTE) && master_reg);
	assign need_high = ((state_reg == two_wire_pkg::S_START) && (phase_reg != 2'h0) &&
		(phase_reg != 2'h3)) || ((state_reg == two_wire_pkg::S_STOP) && (phase_reg == 2'h1)) ||
		((state_reg == two_wire_pkg::S_BYTE) && master_reg && !scl_low_reg);
	assign adv = timed && (cnt_reg >= half_len);

	always_ff @(posedge mclk) begin
		if (!nrst || !timed || adv || (need_high && !link.scl))
			cnt_reg <= 16'h0000;
		else
			cnt_reg <= cnt_reg + 16'h0001;
	end

	// Bus engine
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg <= two_wire_pkg::S_IDLE;
			phase_reg <= 2'h0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			code_reg <= `SC_IDLE;
			master_reg <= 1'b0;
			tx_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			addressed_reg <= 1'b0;
			gc_reg <= 1'b0;
			lost_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			leave_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			set_pulse_reg <= 1'b0;
			stop_clr_reg <= 1'b0;
			latch_reg <= 1'b0;
		end else begin
			set_pulse_reg <= 1'b0;
			stop_clr_reg <= 1'b0;
			latch_reg <= 1'b0;
			if (!enable_reg) begin
				state_reg <= two_wire_pkg::S_IDLE;
				scl_low_reg <= 1'b0;
				sda_low_reg <= 1'b0;
				master_reg <= 1'b0;
			end else begin
				case (state_reg)
					two_wire_pkg::S_IDLE: begin
						scl_low_reg <= 1'b0;
						sda_low_reg <= 1'b0;
						master_reg <= 1'b0;
						addressed_reg <= 1'b0;
						if (link.start_det) begin
							state_reg <= two_wire_pkg::S_BYTE;
							tx_reg <= 1'b0;
							addr_phase_reg <= 1'b1;
							bit_cnt_reg <= 4'h0;
							lost_reg <= 1'b0;
						end else if (start_reg && !flag_reg && !link.busy) begin
							// R14 new START once bus is free
							state_reg <= two_wire_pkg::S_START;
							phase_reg <= 2'h0;
						end
					end
					two_wire_pkg::S_START: begin
						if (adv) begin
							phase_reg <= phase_reg + 2'h1;
							case (phase_reg)
								2'h0: scl_low_reg <= 1'b0;
								2'h1: sda_low_reg <= 1'b1;
								2'h2: scl_low_reg <= 1'b1;
								default: begin
									// R9 repeated START keeps ownership
									code_reg <= master_reg ? `SC_RSTART : `SC_START;
									master_reg <= 1'b1;
									addr_phase_reg <= 1'b1;
									tx_reg <= 1'b1;
									set_pulse_reg <= 1'b1;
									phase_reg <= 2'h0;
									state_reg <= two_wire_pkg::S_HOLD;
								end
							endcase
						end
					end
					two_wire_pkg::S_STOP: begin
						if (adv) begin
							phase_reg <= phase_reg + 2'h1;
							case (phase_reg)
								2'h0: scl_low_reg <= 1'b0;
								2'h1: sda_low_reg <= 1'b0;
								default: begin
									stop_clr_reg <= 1'b1;
									master_reg <= 1'b0;
									state_reg <= two_wire_pkg::S_IDLE;
								end
							endcase
						end
					end
					two_wire_pkg::S_BYTE: begin
						if ((link.start_det || link.stop_det) && bit_cnt_reg >= `BIT_ERR_MIN) begin
							// R4 R20 illegal START/STOP
							code_reg <= `SC_BUS_ERR;
							set_pulse_reg <= 1'b1;
							scl_low_reg <= 1'b0;
							sda_low_reg <= 1'b0;
							master_reg <= 1'b0;
							addressed_reg <= 1'b0;
							state_reg <= two_wire_pkg::S_ERROR;
						end else if ((link.start_det || link.stop_det) && !master_reg) begin
							if (addressed_reg) begin
								code_reg <= `SC_SRX_STOP;
								set_pulse_reg <= 1'b1;
							end
							sda_low_reg <= 1'b0;
							addressed_reg <= 1'b0;
							tx_reg <= 1'b0;
							addr_phase_reg <= 1'b1;
							bit_cnt_reg <= 4'h0;
							lost_reg <= 1'b0;
							state_reg <= link.start_det ? two_wire_pkg::S_BYTE : two_wire_pkg::S_IDLE;
						end else begin
							if (adv)
								scl_low_reg <= !scl_low_reg;
							if (link.scl_rise) begin
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
								if (bit_cnt_reg < `ACK_SLOT)
									shift_reg <= {shift_reg[6:0], link.sda};
								else
									ack_seen_reg <= !link.sda;
								// R11 R12 released high but low seen
								if (master_reg && tx_reg && bit_cnt_reg < `ACK_SLOT &&
									!sda_low_reg && !link.sda) begin
									master_reg <= 1'b0;
									tx_reg <= 1'b0;
									lost_reg <= 1'b1;
									scl_low_reg <= 1'b0;
								end
							end
							if (link.scl_fall) begin
								if (bit_cnt_reg < `ACK_SLOT) begin
									sda_low_reg <= tx_reg && !shift_reg[7];
								end else if (bit_cnt_reg == `ACK_SLOT) begin
									if (addr_phase_reg && !master_reg) begin
										// R15 compare address as slave
										sda_low_reg <= own_hit || gc_hit;
										addressed_reg <= own_hit || gc_hit;
										gc_reg <= gc_hit && !own_hit;
										// R16 direction picks receive or transmit
										tx_reg <= own_hit && shift_reg[0];
									end else begin
										sda_low_reg <= !tx_reg && ack_en_reg &&
											(master_reg || addressed_reg);
									end
								end else begin
									sda_low_reg <= 1'b0;
									bit_cnt_reg <= 4'h0;
									addr_phase_reg <= 1'b0;
									lost_reg <= 1'b0;
									latch_reg <= 1'b1;
									phase_reg <= 2'h0;
									leave_reg <= 1'b0;
									if (master_reg) begin
										set_pulse_reg <= 1'b1;
										state_reg <= two_wire_pkg::S_HOLD;
										if (addr_phase_reg) begin
											tx_reg <= !shift_reg[0];
											if (shift_reg[0])
												code_reg <= ack_seen_reg ? `SC_MRX_SLA_ACK : `SC_MRX_SLA_NACK;
											else
												code_reg <= ack_seen_reg ? `SC_MTX_SLA_ACK : `SC_MTX_SLA_NACK;
										end else if (tx_reg) begin
											code_reg <= ack_seen_reg ? `SC_MTX_DATA_ACK : `SC_MTX_DATA_NACK;
										end else begin
											code_reg <= ack_seen_reg ? `SC_MRX_DATA_ACK : `SC_MRX_DATA_NACK;
										end
									end else if (addressed_reg) begin
										// R17 addressed after loss gets own codes
										set_pulse_reg <= 1'b1;
										scl_low_reg <= 1'b1;
										leave_reg <= !addr_phase_reg && !ack_seen_reg;
										state_reg <= two_wire_pkg::S_HOLD;
										if (addr_phase_reg) begin
											if (tx_reg)
												code_reg <= lost_reg ? `SC_STX_ARB_SLA : `SC_STX_SLA;
											else if (gc_reg)
												code_reg <= lost_reg ? `SC_SRX_ARB_GC : `SC_SRX_GC;
											else
												code_reg <= lost_reg ? `SC_SRX_ARB_SLA : `SC_SRX_SLA;
										end else if (tx_reg) begin
											code_reg <= ack_seen_reg ? `SC_STX_DATA_ACK : `SC_STX_DATA_NACK;
										end else if (gc_reg) begin
											code_reg <= ack_seen_reg ? `SC_SRX_GC_ACK : `SC_SRX_GC_NACK;
										end else begin
											code_reg <= ack_seen_reg ? `SC_SRX_DATA_ACK : `SC_SRX_DATA_NACK;
										end
									end else begin
										// R17 R14 lost and unaddressed releases bus
										if (lost_reg) begin
											code_reg <= `SC_ARB_LOST;
											set_pulse_reg <= 1'b1;
										end
										state_reg <= two_wire_pkg::S_IDLE;
									end
								end
							end
						end
					end
					two_wire_pkg::S_HOLD: begin
						// R19 clock held low while waiting
						if (phase_reg == 2'h1) begin
							scl_low_reg <= 1'b0;
							phase_reg <= 2'h0;
							state_reg <= two_wire_pkg::S_BYTE;
						end else if (go_reg) begin
							if (master_reg && start_reg) begin
								sda_low_reg <= 1'b0;
								state_reg <= two_wire_pkg::S_START;
							end else if (master_reg && stop_reg) begin
								sda_low_reg <= 1'b1;
								state_reg <= two_wire_pkg::S_STOP;
							end else if (!master_reg && (stop_reg || leave_reg)) begin
								stop_clr_reg <= stop_reg;
								scl_low_reg <= 1'b0;
								state_reg <= two_wire_pkg::S_IDLE;
							end else begin
								shift_reg <= data_reg;
								sda_low_reg <= tx_reg && !data_reg[7];
								bit_cnt_reg <= 4'h0;
								lost_reg <= 1'b0;
								if (master_reg)
									state_reg <= two_wire_pkg::S_BYTE;
								else
									phase_reg <= 2'h1;
							end
						end
					end
					two_wire_pkg::S_ERROR: begin
						// R6 R7 R8 recovery releases lines, no STOP
						scl_low_reg <= 1'b0;
						sda_low_reg <= 1'b0;
						if (go_reg && stop_reg) begin
							stop_clr_reg <= 1'b1;
							state_reg <= two_wire_pkg::S_IDLE;
						end
					end
					default: state_reg <= two_wire_pkg::S_IDLE;
				endcase
			end
		end
	end
endmodule : i2c_unit

// [i2c_unit_chk.sv]
// Concurrent checks on the two-wire unit ports
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module i2c_unit_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// Pin enables
	input wire logic scl_drive_en,
	input wire logic sda_drive_en
);
	logic [1:0] pre_reg;
	logic err_reg;
	logic st_q;
	logic st_rd;
	logic ct_rd;
	logic ct_wr;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	assign st_rd = reg_read && reg_addr == `OFS_STATUS;
	assign ct_rd = reg_read && reg_addr == `OFS_CONTROL;
	assign ct_wr = reg_write && reg_addr == `OFS_CONTROL;
	// Mirror of the prescaler bits last written
	always_ff @(posedge mclk) begin
		if (!nrst)
			pre_reg <= 2'h0;
		else if (reg_write && reg_addr == `OFS_STATUS)
			pre_reg <= reg_wdata[1:0];
	end
	// Remembers that software has seen the bus-error code
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_q <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			st_q <= st_rd;
			if (st_q && reg_rdata[7:3] == 5'h00)
				err_reg <= 1'b1;
			else if (ct_wr)
				err_reg <= 1'b0;
		end
	end
	a_status_bit_two: assert property (st_rd |=> reg_rdata[2] == 1'b0)
		else $error("status bit 2 not zero");
	a_prescale_readback: assert property (st_rd |=> reg_rdata[1:0] == pre_reg)
		else $error("prescaler bits differ from last write");
	a_flag_follows_code: assert property (
		st_rd ##1 (reg_rdata[7:3] != 5'h1F) ##1 ct_rd |=> reg_rdata[7])
		else $error("status code shown with done flag clear");
	a_error_lines_free: assert property (
		st_rd ##1 (reg_rdata[7:3] == 5'h00) |-> !scl_drive_en && !sda_drive_en)
		else $error("line driven during bus error");
	a_recovery_no_stop: assert property (
		err_reg && ct_wr && reg_wdata[7] && reg_wdata[4]
		|=> (!scl_drive_en && !sda_drive_en) [*8])
		else $error("line driven after error recovery");
	a_held_clock_low: assert property (
		st_rd ##1 (reg_rdata[7:3] == 5'h01 || reg_rdata[7:3] == 5'h16)
		|-> ##[0:1] scl_drive_en)
		else $error("clock not held while flag set");
	a_lost_releases: assert property (
		st_rd ##1 (reg_rdata[7:3] == 5'h07) |-> ##[0:1] (!scl_drive_en && !sda_drive_en))
		else $error("bus not released after lost arbitration");
	a_disable_frees: assert property (
		ct_wr && !reg_wdata[2] |=> ##2 (!scl_drive_en && !sda_drive_en) [*4])
		else $error("line driven while disabled");
endmodule : i2c_unit_chk

bind i2c_unit i2c_unit_chk i_chk (
	.mclk(mclk),
	.nrst(nrst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.scl_drive_en(scl_drive_en),
	.sda_drive_en(sda_drive_en)
);

// [bus_partner.sv]
// Behavioural far-side master on the shared two-wire bus
`timescale 1ns/1ps
module bus_partner #(
	parameter int HALF = 10
) (
	// Clock
	input wire logic mclk,
	// Wire levels
	input wire logic scl_w,
	input wire logic sda_w,
	// Pull-down requests
	output logic scl_low,
	output logic sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic start_cond();
		@(posedge mclk);
		sda_low <= 1'b1;
		tick(HALF);
	endtask : start_cond
	// Joins a START made by another master at the same moment
	task automatic join_start();
		wait (sda_w == 1'b0);
		@(posedge mclk);
		sda_low <= 1'b1;
		tick(HALF);
	endtask : join_start
	// One bit with clock synchronisation: low phase stretched by others, high ends early
	task automatic bit_io(input logic b, output logic r);
		int n;
		n = 0;
		@(posedge mclk);
		scl_low <= 1'b1;
		tick(2);
		sda_low <= !b;
		tick(HALF - 2);
		scl_low <= 1'b0;
		wait (scl_w == 1'b1);
		tick(2);
		r = sda_w;
		while (n < HALF - 2 && scl_w) begin
			@(posedge mclk);
			n++;
		end
	endtask : bit_io
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
	endtask : byte_io
	task automatic stop_cond();
		@(posedge mclk);
		scl_low <= 1'b1;
		tick(2);
		sda_low <= 1'b1;
		tick(HALF);
		scl_low <= 1'b0;
		wait (scl_w == 1'b1);
		tick(HALF);
		sda_low <= 1'b0;
		tick(HALF);
	endtask : stop_cond
endmodule : bus_partner

// [i2c_unit_tb.sv]
// Self-checking bench for the two-wire unit
`timescale 1ns/1ps
`include "two_wire_regs.svh"
module i2c_unit_tb;
	logic mclk;
	logic nrst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [7:0] reg_rdata;
	logic scl_drive_en;
	logic sda_drive_en;
	logic scl_value;
	logic sda_value;
	logic scl_low;
	logic sda_low;
	logic scl_w;
	logic sda_w;
	int fail_count = 0;
	int samples_checked = 0;
	// Open-drain wires with pull-ups
	assign scl_w = !((scl_drive_en && !scl_value) || scl_low);
	assign sda_w = !((sda_drive_en && !sda_value) || sda_low);
	i2c_unit i_dut (
		.mclk(mclk),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.scl_line(scl_w),
		.scl_value(scl_value),
		.scl_drive_en(scl_drive_en),
		.sda_line(sda_w),
		.sda_value(sda_value),
		.sda_drive_en(sda_drive_en)
	);
	bus_partner #(.HALF(10)) i_partner (
		.mclk(mclk),
		.scl_w(scl_w),
		.sda_w(sda_w),
		.scl_low(scl_low),
		.sda_low(sda_low)
	);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	// only the status register is polled while waiting
	task automatic wait_code(input logic [7:0] code);
		logic [7:0] d;
		for (int n = 0; n < 3000; n++) begin
			rd(`OFS_STATUS, d);
			if (d === code)
				break;
		end
		check("status code", d, code);
	endtask : wait_code
	task automatic check_free();
		check("clock enable", {7'h00, scl_drive_en}, 8'h00);
		check("data enable", {7'h00, sda_drive_en}, 8'h00);
	endtask : check_free
	task automatic t_reset();
		logic [7:0] d;
		rd(`OFS_STATUS, d); check("status reset", d, `SC_IDLE);
		rd(`OFS_CONTROL, d); check("control reset", d, 8'h00);
		rd(`OFS_OWN_ADDR, d); check("own address reset", d, `RST_OWN_ADDR);
		rd(`OFS_DATA, d); check("data reset", d, `RST_DATA);
		rd(`OFS_BIT_RATE, d); check("bit rate reset", d, `RST_BIT_RATE);
		rd(8'hB7, d); check("unmapped read", d, 8'h00);
		wr(`OFS_STATUS, 8'h03);
		rd(`OFS_STATUS, d); check("prescaler readback", d, 8'hFB);
		wr(`OFS_STATUS, 8'h00);
	endtask : t_reset
	task automatic t_bus_error();
		logic [7:0] d;
		logic r;
		wr(`OFS_OWN_ADDR, 8'h20);
		wr(`OFS_BIT_RATE, 8'h02);
		wr(`OFS_CONTROL, 8'h44);
		i_partner.start_cond();
		for (int i = 0; i < 3; i++)
			i_partner.bit_io(i[0], r);
		i_partner.stop_cond();
		wait_code(`SC_BUS_ERR);
		rd(`OFS_CONTROL, d); check("flag on error", d, 8'hC4);
		check_free();
		// stop request with done flag written one
		wr(`OFS_CONTROL, 8'hD4);
		rd(`OFS_STATUS, d); check("status after recovery", d, `SC_IDLE);
		rd(`OFS_CONTROL, d); check("control after recovery", d, 8'h44);
		check_free();
	endtask : t_bus_error
	// address phase then repeated START with no STOP between
	task automatic t_restart();
		logic [7:0] d;
		wr(`OFS_CONTROL, 8'hE4);
		wait_code(`SC_START);
		wr(`OFS_DATA, 8'hA0);
		wr(`OFS_CONTROL, 8'hC4);
		wait_code(`SC_MTX_SLA_NACK);
		check("clock held", {7'h00, scl_drive_en}, 8'h01);
		wr(`OFS_CONTROL, 8'hE4);
		wait_code(`SC_RSTART);
		wr(`OFS_CONTROL, 8'hD4);
		repeat (60) @(posedge mclk);
		rd(`OFS_CONTROL, d);
		check("stop cleared", d, 8'h44);
		check_free();
	endtask : t_restart
	task automatic t_arb(input logic [7:0] pa, input logic [7:0] code);
		logic [7:0] rx;
		logic ack;
		fork
			begin
				i_partner.join_start();
				i_partner.byte_io(pa, rx);
				i_partner.bit_io(1'b1, ack);
				check("address ack", {7'h00, ack}, {7'h00, code != `SC_STX_ARB_SLA});
				if (!ack) begin
					i_partner.byte_io(8'hFF, rx);
					i_partner.bit_io(1'b1, ack);
					check("byte from loser", rx, 8'h5A);
				end
				i_partner.stop_cond();
			end
			begin
				wr(`OFS_CONTROL, 8'hE4);
				wait_code(`SC_START);
				wr(`OFS_DATA, 8'h34);
				wr(`OFS_CONTROL, 8'hC4);
				wait_code(code);
				if (code == `SC_STX_ARB_SLA) begin
					wr(`OFS_DATA, 8'h5A);
					wr(`OFS_CONTROL, 8'hC4);
					wait_code(`SC_STX_DATA_NACK);
				end
				wr(`OFS_CONTROL, 8'hC4);
			end
		join
		wait_code(`SC_IDLE);
		check_free();
	endtask : t_arb
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		end_sim();
	end
	initial begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_bus_error();
		t_restart();
		t_arb(8'h21, `SC_STX_ARB_SLA);
		t_arb(8'h25, `SC_ARB_LOST);
		wr(`OFS_CONTROL, 8'h00);
		repeat (8) @(posedge mclk);
		end_sim();
	end
endmodule : i2c_unit_tb
